// *** shared/ordm_pkg.sv ***
/*
 * Constants and carrier types of the per-channel optical receive
 * diagnostic map. Assumes one 40 MHz clock; the management link and all
 * measurement strobes are already synchronous to it.
 */
`default_nettype none
package ordm_pkg;
	// Management addresses, eight-bit form with the direction bit clear
	localparam logic [7:0] DEV_ADDR_CH0   = 8'ha2;
	localparam logic [7:0] DEV_ADDR_CH1   = 8'hb2;
	// Byte offsets of the diagnostic map
	localparam logic [7:0] OFF_TEMP_HI    = 8'h60;
	localparam logic [7:0] OFF_TEMP_LO    = 8'h61;
	localparam logic [7:0] OFF_VCC_HI     = 8'h62;
	localparam logic [7:0] OFF_VCC_LO     = 8'h63;
	localparam logic [7:0] OFF_PWR_HI     = 8'h68;
	localparam logic [7:0] OFF_PWR_LO     = 8'h69;
	localparam logic [7:0] OFF_STATUS     = 8'h6e;
	localparam logic [7:0] OFF_UPDATE     = 8'h6f;
	localparam logic [7:0] OFF_ENV_ALARM  = 8'h70;
	localparam logic [7:0] OFF_PWR_ALARM  = 8'h71;
	localparam logic [7:0] OFF_ENV_WARN   = 8'h74;
	localparam logic [7:0] OFF_PWR_WARN   = 8'h75;
	localparam logic [7:0] OFF_SCRATCH_LO = 8'h80;
	localparam logic [7:0] OFF_SCRATCH_HI = 8'hf7;
	localparam int         SCRATCH_BYTES  = 120;
	localparam int         THR_BYTES      = 40;
	// Threshold pairs, high byte at the lower offset
	localparam logic [7:0] THR_TEMP_HA    = 8'h00;
	localparam logic [7:0] THR_TEMP_LA    = 8'h02;
	localparam logic [7:0] THR_TEMP_HW    = 8'h04;
	localparam logic [7:0] THR_TEMP_LW    = 8'h06;
	localparam logic [7:0] THR_VCC_HA     = 8'h08;
	localparam logic [7:0] THR_VCC_LA     = 8'h0a;
	localparam logic [7:0] THR_VCC_HW     = 8'h0c;
	localparam logic [7:0] THR_VCC_LW     = 8'h0e;
	localparam logic [7:0] THR_PWR_HA     = 8'h20;
	localparam logic [7:0] THR_PWR_LA     = 8'h22;
	localparam logic [7:0] THR_PWR_HW     = 8'h24;
	localparam logic [7:0] THR_PWR_LW     = 8'h26;
	// Field positions
	localparam int         SIGNAL_LOST_BIT = 1;
	localparam int         UPD_TEMP_BIT   = 7;
	localparam int         UPD_VCC_BIT    = 6;
	localparam int         UPD_PWR_BIT    = 3;
	// Reset values
	localparam logic [15:0] MEAS_RST      = 16'h0000;
	localparam logic [7:0]  BYTE_RST      = 8'h00;

	// One channel's measurement input
	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] vcc;
		logic [15:0] pwr;
		logic        tempStb;
		logic        vccStb;
		logic        pwrStb;
		logic        receiveSignalLost;
	} ordm_meas_s;

	// One channel's live register image
	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] vcc;
		logic [15:0] pwr;
		logic [2:0]  upd;    // Temp, vcc, power
		logic [3:0]  envAlm; // Temp hi, temp lo, vcc hi, vcc lo
		logic [1:0]  pwrAlm; // Power hi, power lo
		logic [3:0]  envWrn;
		logic [1:0]  pwrWrn;
		logic        signalLost;
	} ordm_chan_s;

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
	} ordm_link_e;
endpackage
`default_nettype wire

// *** core/ordm_diag_map.sv ***
/*
 * Two-channel diagnostic register map behind a two-wire management slave.
 * Assumes scl and sda are already synchronous to mclk and that the
 * board provides the open-drain wire resolution from sdaOut/sdaOeN.
 */
// Notes on behaviour
// - Temperature word at offsets 96 and 97.
// - Supply voltage word at offsets 98 and 99.
// - Received power word at offsets 104 and 105.
// - Offset 110 bit 1 mirrors signal loss.
// - Update bit 7 set on temperature update.
// - Update bit 6 set on voltage update.
// - Update bit 3 set on power update.
// - Alarm bit 7: temperature above high alarm.
// - Alarm bit 6: temperature below low alarm.
// - Alarm bit 5: voltage above high alarm.
// - Alarm bit 4: voltage below low alarm.
// - Power alarm bit 7: power above high.
// - Power alarm bit 6: power below low.
// - Warning bit 7: temperature above high warning.
// - Warning bit 6: temperature below low warning.
// - Warning bit 5: voltage above high warning.
// - Warning bit 4: voltage below low warning.
// - Power warning bit 7: power above high.
// - Power warning bit 6: power below low.
// - Address A2h is channel one, B2h two.
// - Thresholds are words, high byte first, low map.
`timescale 1ns/1ps
`default_nettype none
module ordm_diag_map (
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire logic                  scl,
	input  wire logic                  sdaIn,
	output logic                       sdaOut,
	output logic                       sdaOeN,
	input  wire ordm_pkg::ordm_meas_s  meas [2]
);
	import ordm_pkg::*;

	// ==================================================================
	// Reset release
	// ==================================================================
	logic [1:0] rstSync;
	logic       rstN;

	// Two-stage release of the asynchronous reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rstSync <= 2'b00;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	// ==================================================================
	// State and memories
	// ==================================================================
	typedef struct packed {
		ordm_link_e  st;
		logic        sclQ;
		logic        sdaQ;
		logic [7:0]  shift;
		logic [3:0]  bitCnt;
		logic        chan;
		logic        rw;
		logic        havePtr;
		logic        driveLow;
		logic        hostAck;
		logic [1:0][7:0] ptr;
		ordm_chan_s [1:0] ch;
	} ordm_state_s;

	ordm_state_s cur;
	ordm_state_s next_cur;

	logic [7:0] thrMem  [2][THR_BYTES];
	logic [7:0] scratch [SCRATCH_BYTES];

	logic       wrEn;
	logic       wrCh;
	logic [7:0] wrOff;
	logic [7:0] wrData;
	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;

	// Bus condition detection on the sampled pins
	assign sclRise   = scl & ~cur.sclQ;
	assign sclFall   = ~scl & cur.sclQ;
	assign startCond = cur.sclQ & scl & cur.sdaQ & ~sdaIn;
	assign stopCond  = cur.sclQ & scl & ~cur.sdaQ & sdaIn;

	// ==================================================================
	// Helpers
	// ==================================================================
	// Threshold word, high byte at the lower offset
	function automatic logic [15:0] thrWord(input logic c, input logic [7:0] off);
		thrWord = {thrMem[c][off[5:0]], thrMem[c][off[5:0] + 6'd1]};
	endfunction

	// Readable byte of one channel's map; unmapped bytes read zero
	function automatic logic [7:0] mapByte(input logic c, input ordm_chan_s r,
	                                       input logic [7:0] off);
		logic [7:0] idx;
		idx = off - OFF_SCRATCH_LO;
		mapByte = BYTE_RST;
		if (off < 8'(THR_BYTES)) begin
			mapByte = thrMem[c][off[5:0]];
		end else if (c && off >= OFF_SCRATCH_LO && off <= OFF_SCRATCH_HI) begin
			mapByte = scratch[idx[6:0]];
		end else begin
			case (off)
				OFF_TEMP_HI:   mapByte = r.temp[15:8];
				OFF_TEMP_LO:   mapByte = r.temp[7:0];
				OFF_VCC_HI:    mapByte = r.vcc[15:8];
				OFF_VCC_LO:    mapByte = r.vcc[7:0];
				OFF_PWR_HI:    mapByte = r.pwr[15:8];
				OFF_PWR_LO:    mapByte = r.pwr[7:0];
				OFF_STATUS:    mapByte = 8'(r.signalLost) << SIGNAL_LOST_BIT;
				OFF_UPDATE:    mapByte = (8'(r.upd[2]) << UPD_TEMP_BIT)
				                       | (8'(r.upd[1]) << UPD_VCC_BIT)
				                       | (8'(r.upd[0]) << UPD_PWR_BIT);
				OFF_ENV_ALARM: mapByte = {r.envAlm, 4'h0};
				OFF_PWR_ALARM: mapByte = {r.pwrAlm, 6'h00};
				OFF_ENV_WARN:  mapByte = {r.envWrn, 4'h0};
				OFF_PWR_WARN:  mapByte = {r.pwrWrn, 6'h00};
				default:       mapByte = BYTE_RST;
			endcase
		end
	endfunction

	// ==================================================================
	// Next-state logic
	// ==================================================================
	always_comb begin
		next_cur = cur;
		wrEn     = 1'b0;
		wrCh     = 1'b0;
		wrOff    = BYTE_RST;
		wrData   = BYTE_RST;
		next_cur.sclQ = scl;
		next_cur.sdaQ = sdaIn;

		// Management link slave
		if (startCond) begin
			next_cur.st       = ST_ADDR;
			next_cur.bitCnt   = 4'h0;
			next_cur.driveLow = 1'b0;
			next_cur.havePtr  = 1'b0;
		end else if (stopCond) begin
			next_cur.st       = ST_IDLE;
			next_cur.driveLow = 1'b0;
		end else begin
			case (cur.st)
				ST_IDLE: begin
					next_cur.driveLow = 1'b0;
				end
				ST_ADDR, ST_WR: begin
					if (sclRise && cur.bitCnt < 4'h8) begin
						next_cur.shift  = {cur.shift[6:0], sdaIn};
						next_cur.bitCnt = cur.bitCnt + 4'h1;
					end else if (sclFall && cur.bitCnt == 4'h8) begin
						if (cur.st == ST_ADDR) begin
							// Channel chosen by device address
							if (cur.shift[7:1] == DEV_ADDR_CH0[7:1] ||
							    cur.shift[7:1] == DEV_ADDR_CH1[7:1]) begin
								next_cur.chan     = (cur.shift[7:1] == DEV_ADDR_CH1[7:1]);
								next_cur.rw       = cur.shift[0];
								next_cur.driveLow = 1'b1;
								next_cur.st       = ST_AACK;
							end else begin
								next_cur.st = ST_IDLE;
							end
						end else begin
							// First byte sets the pointer, later ones are data
							next_cur.driveLow = 1'b1;
							next_cur.st       = ST_WACK;
							if (!cur.havePtr) begin
								next_cur.ptr[cur.chan] = cur.shift;
								next_cur.havePtr       = 1'b1;
							end else begin
								wrEn   = 1'b1;
								wrCh   = cur.chan;
								wrOff  = cur.ptr[cur.chan];
								wrData = cur.shift;
								next_cur.ptr[cur.chan] = cur.ptr[cur.chan] + 8'h01;
							end
						end
					end
				end
				ST_AACK, ST_RACK: begin
					if (sclRise) begin
						next_cur.hostAck = ~sdaIn;
					end else if (sclFall) begin
						if (cur.st == ST_AACK && !cur.rw) begin
							next_cur.driveLow = 1'b0;
							next_cur.bitCnt   = 4'h0;
							next_cur.st       = ST_WR;
						end else if (cur.st == ST_AACK || cur.hostAck) begin
							// Load the next byte and drive its top bit
							next_cur.shift    = mapByte(cur.chan, cur.ch[cur.chan],
							                            cur.ptr[cur.chan]);
							next_cur.driveLow = ~next_cur.shift[7];
							next_cur.bitCnt   = 4'h1;
							next_cur.st       = ST_RD;
							if (cur.ptr[cur.chan] == OFF_UPDATE) begin
								next_cur.ch[cur.chan].upd = 3'b000;
							end
						end else begin
							next_cur.driveLow = 1'b0;
							next_cur.st       = ST_IDLE;
						end
					end
				end
				ST_WACK: begin
					if (sclFall) begin
						next_cur.driveLow = 1'b0;
						next_cur.bitCnt   = 4'h0;
						next_cur.st       = ST_WR;
					end
				end
				ST_RD: begin
					if (sclFall) begin
						if (cur.bitCnt == 4'h8) begin
							next_cur.driveLow      = 1'b0;
							next_cur.st            = ST_RACK;
							next_cur.ptr[cur.chan] = cur.ptr[cur.chan] + 8'h01;
						end else begin
							next_cur.shift    = {cur.shift[6:0], 1'b0};
							next_cur.driveLow = ~cur.shift[6];
							next_cur.bitCnt   = cur.bitCnt + 4'h1;
						end
					end
				end
				default: begin
					next_cur.st       = ST_IDLE;
					next_cur.driveLow = 1'b0;
				end
			endcase
		end

		// Measurement capture after the link, so a new update beats a read clear
		for (int c = 0; c < 2; c++) begin
			next_cur.ch[c].signalLost = meas[c].receiveSignalLost;
			if (meas[c].tempStb) begin
				next_cur.ch[c].temp   = meas[c].temp;
				next_cur.ch[c].upd[2] = 1'b1;
				next_cur.ch[c].envAlm[3] =
					$signed(meas[c].temp) > $signed(thrWord(1'(c), THR_TEMP_HA));
				next_cur.ch[c].envAlm[2] =
					$signed(meas[c].temp) < $signed(thrWord(1'(c), THR_TEMP_LA));
				next_cur.ch[c].envWrn[3] =
					$signed(meas[c].temp) > $signed(thrWord(1'(c), THR_TEMP_HW));
				next_cur.ch[c].envWrn[2] =
					$signed(meas[c].temp) < $signed(thrWord(1'(c), THR_TEMP_LW));
			end
			if (meas[c].vccStb) begin
				next_cur.ch[c].vcc    = meas[c].vcc;
				next_cur.ch[c].upd[1] = 1'b1;
				next_cur.ch[c].envAlm[1] = meas[c].vcc > thrWord(1'(c), THR_VCC_HA);
				next_cur.ch[c].envAlm[0] = meas[c].vcc < thrWord(1'(c), THR_VCC_LA);
				next_cur.ch[c].envWrn[1] = meas[c].vcc > thrWord(1'(c), THR_VCC_HW);
				next_cur.ch[c].envWrn[0] = meas[c].vcc < thrWord(1'(c), THR_VCC_LW);
			end
			if (meas[c].pwrStb) begin
				next_cur.ch[c].pwr    = meas[c].pwr;
				next_cur.ch[c].upd[0] = 1'b1;
				next_cur.ch[c].pwrAlm[1] = meas[c].pwr > thrWord(1'(c), THR_PWR_HA);
				next_cur.ch[c].pwrAlm[0] = meas[c].pwr < thrWord(1'(c), THR_PWR_LA);
				next_cur.ch[c].pwrWrn[1] = meas[c].pwr > thrWord(1'(c), THR_PWR_HW);
				next_cur.ch[c].pwrWrn[0] = meas[c].pwr < thrWord(1'(c), THR_PWR_LW);
			end
		end
	end

	// ==================================================================
	// Registers
	// ==================================================================
	// State register
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			cur <= '0;
			cur.sclQ <= 1'b1;
			cur.sdaQ <= 1'b1;
			cur.st   <= ST_IDLE;
		end else begin
			cur <= next_cur;
		end
	end

	// Host-writable threshold and scratch bytes
	always_ff @(posedge mclk) begin
		if (wrEn && wrOff < 8'(THR_BYTES)) begin
			thrMem[wrCh][wrOff[5:0]] <= wrData;
		end
		if (wrEn && wrCh && wrOff >= OFF_SCRATCH_LO && wrOff <= OFF_SCRATCH_HI) begin
			scratch[7'(wrOff - OFF_SCRATCH_LO)] <= wrData;
		end
	end

	// Open-drain data pin: only ever pulls low
	assign sdaOut = 1'b0;
	assign sdaOeN = ~cur.driveLow;

	// ==================================================================
	// Checks
	// ==================================================================
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rstN);

	// Update bytes as the host would read them
	logic [1:0][7:0] updByte;
	assign updByte = {mapByte(1'b1, cur.ch[1], OFF_UPDATE),
	                  mapByte(1'b0, cur.ch[0], OFF_UPDATE)};

	AST_TEMP_WORD: assert property (meas[0].tempStb |=>
		mapByte(1'b0, cur.ch[0], OFF_TEMP_HI) == $past(meas[0].temp[15:8]) &&
		mapByte(1'b0, cur.ch[0], OFF_TEMP_LO) == $past(meas[0].temp[7:0]))
		else $error("temperature word not presented");
	AST_VCC_WORD: assert property (meas[1].vccStb |=>
		mapByte(1'b1, cur.ch[1], OFF_VCC_HI) == $past(meas[1].vcc[15:8]))
		else $error("voltage word not presented");
	AST_PWR_WORD: assert property (meas[0].pwrStb |=>
		mapByte(1'b0, cur.ch[0], OFF_PWR_LO) == $past(meas[0].pwr[7:0]))
		else $error("power word not presented");
	AST_SIGNAL_LOST: assert property (##1
		mapByte(1'b0, cur.ch[0], OFF_STATUS) == {6'h00, $past(meas[0].receiveSignalLost), 1'b0})
		else $error("status byte wrong");
	AST_UPD_SET: assert property (meas[0].tempStb |=>
		updByte[0][UPD_TEMP_BIT] ##1
		(updByte[0][UPD_TEMP_BIT] || $past(cur.st) != ST_RD))
		else $error("temperature update bit not set");
	AST_PWR_HI_ALARM: assert property (meas[0].pwrStb &&
		meas[0].pwr > thrWord(1'b0, THR_PWR_HA) |=> cur.ch[0].pwrAlm[1])
		else $error("power high alarm missed");
	AST_VCC_LO_WARN: assert property (meas[1].vccStb &&
		meas[1].vcc >= thrWord(1'b1, THR_VCC_LW) |=> !cur.ch[1].envWrn[0])
		else $error("voltage low warning false");
	AST_FLAG_HOLD: assert property (!meas[0].tempStb |=> $stable(cur.ch[0].envAlm[3:2]))
		else $error("temperature alarm changed without update");
	AST_ADDR_ACK: assert property (cur.st == ST_ADDR && sclFall &&
		cur.bitCnt == 4'h8 && cur.shift[7:1] == DEV_ADDR_CH1[7:1] && !startCond && !stopCond
		|=> !sdaOeN && cur.chan)
		else $error("channel two address not acknowledged");
	AST_UPD_VCC: assert property (meas[1].vccStb |=> updByte[1][UPD_VCC_BIT])
		else $error("voltage update bit not set");
	AST_UPD_PWR: assert property (meas[0].pwrStb |=> updByte[0][UPD_PWR_BIT])
		else $error("power update bit not set");
	AST_TEMP_LO_ALARM: assert property (meas[1].tempStb &&
		$signed(meas[1].temp) < $signed(thrWord(1'b1, THR_TEMP_LA)) |=> cur.ch[1].envAlm[2])
		else $error("temperature low alarm missed");
	AST_VCC_HI_ALARM: assert property (meas[0].vccStb &&
		meas[0].vcc > thrWord(1'b0, THR_VCC_HA) |=> cur.ch[0].envAlm[1])
		else $error("voltage high alarm missed");
	AST_PWR_HI_WARN: assert property (meas[1].pwrStb &&
		meas[1].pwr > thrWord(1'b1, THR_PWR_HW) |=> cur.ch[1].pwrWrn[1])
		else $error("power high warning missed");
	AST_SCRATCH: assert property (wrEn && wrCh && wrOff == OFF_SCRATCH_LO |=>
		mapByte(1'b1, cur.ch[1], OFF_SCRATCH_LO) == $past(wrData))
		else $error("scratch byte not read back");

	// Main scenarios reached
	COV_READ: cover property (cur.st == ST_RD && cur.chan);
	COV_WRITE: cover property (wrEn && wrCh);
	COV_ALARM: cover property (cur.ch[0].envAlm[3]);
	COV_UPD_CLEAR: cover property (cur.st == ST_RD && cur.ptr[cur.chan] == OFF_UPDATE);
	COV_FOREIGN: cover property (cur.st == ST_ADDR && sclFall && cur.bitCnt == 4'h8 &&
		cur.shift[7:1] != DEV_ADDR_CH0[7:1] && cur.shift[7:1] != DEV_ADDR_CH1[7:1]);
endmodule
`default_nettype wire

// *** dv/ordm_host_model.sv ***
/*
 * Host two-wire management controller model for the diagnostic map.
 * Assumes the bench resolves the open-drain sda wire with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module ordm_host_model (
	input  wire logic mclk,
	input  wire logic sdaWire,
	output var logic  scl,
	output var logic  hostSdaOeN
);
	localparam int Q = 4; // Mclk cycles per quarter bit

	// Idle bus: both lines released
	initial begin
		scl = 1'b1;
		hostSdaOeN = 1'b1;
	end

	// ==========================================
	// Bit level
	task automatic wq();
		repeat (Q) @(negedge mclk);
	endtask

	// Start or repeated start
	task automatic start();
		hostSdaOeN = 1'b1;
		wq();
		scl = 1'b1;
		wq();
		hostSdaOeN = 1'b0;
		wq();
		scl = 1'b0;
		wq();
	endtask

	task automatic stop();
		hostSdaOeN = 1'b0;
		wq();
		scl = 1'b1;
		wq();
		hostSdaOeN = 1'b1;
		wq();
	endtask

	// Sda changes only while scl is low; sampled mid high phase
	task automatic bitx(input logic b, output logic r);
		hostSdaOeN = b;
		wq();
		scl = 1'b1;
		wq();
		r = sdaWire;
		wq();
		scl = 1'b0;
		wq();
	endtask

	// Eight bits msb first, then the acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
			output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(ackIn, r);
		ack = ~r;
	endtask

	// ==========================================
	// Transaction level
	task automatic wrMap(input logic [7:0] dev, input logic [7:0] off,
			input logic [7:0] d[$], output logic ok);
		logic [7:0] q;
		logic       a;
		start();
		xfer(dev, 1'b1, q, ok);
		xfer(off, 1'b1, q, a);
		ok &= a;
		foreach (d[i]) begin
			xfer(d[i], 1'b1, q, a);
			ok &= a;
		end
		stop();
	endtask

	// Pointer write, repeated start, read with ack on all but the last byte
	task automatic rdMap(input logic [7:0] dev, input logic [7:0] off, input int n,
			output logic [7:0] r[$], output logic ok);
		logic [7:0] q;
		logic       a;
		start();
		xfer(dev, 1'b1, q, ok);
		xfer(off, 1'b1, q, a);
		ok &= a;
		start();
		xfer(dev | 8'h01, 1'b1, q, a);
		ok &= a;
		for (int i = 0; i < n; i++) begin
			xfer(8'hff, i == n - 1, q, a);
			r.push_back(q);
		end
		stop();
	endtask

	task automatic probe(input logic [7:0] dev, output logic ok);
		logic [7:0] q;
		start();
		xfer(dev, 1'b1, q, ok);
		stop();
	endtask
endmodule
`default_nettype wire

// *** dv/optical_rx_diag_monitor_map_tb.sv ***
/*
 * Self-checking bench of the two-channel diagnostic map.
 * Assumes the host model drives the management link; sda has a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module optical_rx_diag_monitor_map_tb;
	import ordm_pkg::*;
	logic       mclk = 1'b0;
	logic       rst_n;
	logic       scl;
	logic       hostSdaOeN;
	logic       sdaOut;
	logic       sdaOeN;
	wire logic  sdaWire;
	ordm_meas_s meas [2];
	int         num_errors = 0;
	int         checked = 0;
	localparam logic [7:0] TV [4] = '{8'h50, 8'h10, 8'h40, 8'h20};

	// ==========================================
	// Clock, wire and instances
	always #12.5 mclk = ~mclk;

	// Open-drain wire with pull-up
	assign sdaWire = hostSdaOeN & (sdaOeN | sdaOut);

	ordm_diag_map i_dut (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOeN(sdaOeN), .meas(meas));
	ordm_host_model i_host (.mclk(mclk), .sdaWire(sdaWire), .scl(scl),
		.hostSdaOeN(hostSdaOeN));

	// ==========================================
	// Helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [7:0] thr(input logic [7:0] o);
		return o[0] ? TV[o[2:1]] : 8'h00;
	endfunction

	// Flags as {above high alarm, below low alarm, above high warn, below low warn}
	function automatic logic [3:0] flg(input logic [15:0] x, input logic sgn);
		logic signed [16:0] v;
		v = sgn ? {x[15], x} : {1'b0, x};
		return {v > 17'sh50, v < 17'sh10, v > 17'sh40, v < 17'sh20};
	endfunction

	task automatic stop_test();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task automatic tBadAddr();
		logic ok;
		i_host.probe(8'ha0, ok);
		chk({7'h00, ok}, 8'h00, "foreign address acked");
	endtask

	task automatic tThr();
		logic [7:0] d[$];
		logic [7:0] r[$];
		logic       ok;
		for (int o = 0; o < THR_BYTES; o++) d.push_back(thr(o[7:0]));
		for (int c = 0; c < 2; c++) begin
			i_host.wrMap(c ? DEV_ADDR_CH1 : DEV_ADDR_CH0, 8'h00, d, ok);
			chk({7'h00, ok}, 8'h01, "thr write ack");
			i_host.rdMap(c ? DEV_ADDR_CH1 : DEV_ADDR_CH0, 8'h00, THR_BYTES, r, ok);
			foreach (d[k]) chk(r[k], d[k], "thr readback");
		end
	endtask

	task automatic tMeas(input int ch);
		logic [15:0] vals [6] = '{16'h0060, 16'h0048, 16'h0030, 16'h000f, 16'h004f, 16'hff80};
		logic [15:0] t, v, p;
		logic [3:0]  ft, fv, fp;
		logic [7:0]  r[$];
		logic [7:0]  dev;
		logic        ok, lost;
		dev = ch ? DEV_ADDR_CH1 : DEV_ADDR_CH0;
		for (int i = 0; i < 6; i++) begin
			t = vals[i] ^ {15'h0000, ch[0]};
			v = t + 16'h0001;
			p = t + 16'h0002;
			lost = i[0];
			ft = flg(t, 1'b1);
			fv = flg(v, 1'b0);
			fp = flg(p, 1'b0);
			// One-cycle strobes on all three measurements
			@(negedge mclk);
			meas[ch] = {t, v, p, 3'b111, lost};
			@(negedge mclk);
			meas[ch] = {t, v, p, 3'b000, lost};
			i_host.rdMap(dev, OFF_TEMP_HI, 22, r, ok);
			chk({7'h00, ok}, 8'h01, "read ack");
			chk(r[0], t[15:8], "temp hi");
			chk(r[1], t[7:0], "temp lo");
			chk(r[2], v[15:8], "vcc hi");
			chk(r[3], v[7:0], "vcc lo");
			chk(r[8], p[15:8], "pwr hi");
			chk(r[9], p[7:0], "pwr lo");
			chk(r[14], {6'h00, lost, 1'b0}, "status");
			chk(r[15], 8'hc8, "update");
			chk(r[16], {ft[3:2], fv[3:2], 4'h0}, "env alarm");
			chk(r[17], {fp[3:2], 6'h00}, "pwr alarm");
			chk(r[20], {ft[1:0], fv[1:0], 4'h0}, "env warn");
			chk(r[21], {fp[1:0], 6'h00}, "pwr warn");
			foreach (r[k]) if (k inside {[4:7], [10:13], [18:19]}) chk(r[k], 8'h00, "rsvd");
			i_host.rdMap(dev, OFF_UPDATE, 1, r, ok);
			chk(r[0], 8'h00, "update after read");
		end
		// Other channel keeps its own word
		i_host.rdMap(DEV_ADDR_CH0, OFF_TEMP_LO, 1, r, ok);
		if (ch == 1) chk(r[0], 8'h80, "channel one word");
	endtask

	task automatic tScratch();
		logic [7:0] w[$];
		logic [7:0] r[$];
		logic       ok;
		w = {8'haa, 8'h55, 8'hc3};
		i_host.wrMap(DEV_ADDR_CH1, 8'hf6, w, ok);
		chk({7'h00, ok}, 8'h01, "scratch ack");
		i_host.rdMap(DEV_ADDR_CH1, 8'hf6, 3, r, ok);
		chk(r[0], 8'haa, "scratch 246");
		chk(r[1], 8'h55, "scratch 247");
		chk(r[2], 8'h00, "reserved 248");
		w = {8'h3c};
		i_host.wrMap(DEV_ADDR_CH1, OFF_SCRATCH_LO, w, ok);
		i_host.rdMap(DEV_ADDR_CH1, OFF_SCRATCH_LO, 1, r, ok);
		chk(r[0], 8'h3c, "scratch 128");
		i_host.rdMap(DEV_ADDR_CH0, OFF_SCRATCH_LO, 1, r, ok);
		chk(r[0], 8'h00, "no scratch on channel one");
	endtask

	// ==========================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		meas[0] = '0;
		meas[1] = '0;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		tBadAddr();
		tThr();
		tMeas(0);
		tMeas(1);
		tScratch();
		stop_test();
	end

	// Watchdog against a hung bus
	initial begin
		repeat (90000) @(posedge mclk);
		num_errors++;
		$display("BAD %0t watchdog expired", $time);
		stop_test();
	end
endmodule
`default_nettype wire
